// [logic/light_readout.sv]
// conversion sequencing, result buffering and threshold interrupt of the light readout
// Behaviour
// - both channels integrate over one shared period
// - converter 0 to channel 0, 1 to 1
// - double-buffered results, reads never mix conversions
// - next integration starts by itself after transfer
// - interrupt is a level, held until cleared
// - two threshold pairs, above upper or below lower
// - one pair fires after programmed consecutive conversions
// - other pair fires on first out-of-range conversion
// - interrupt pin open drain, pulled low when asserted
// - serial target port, fast mode rates
// - 3-bit time code, 100 ms steps, up to 600 ms
module light_readout
	import light_readout_pkg::*;
#(
	parameter int unsigned STEP_LEN = STEP_CYCLES     // cycles per integration step
) (
	input  wire logic                clock,                // 25 MHz system clock
	input  wire logic                resetn,               // async reset, active low
	input  wire logic [ITIME_W-1:0]  integration_time_sel, // integration time code
	input  wire logic                adc0_tick,            // converter 0 charge quantum, 1 cycle
	input  wire logic                adc1_tick,            // converter 1 charge quantum, 1 cycle
	input  wire logic [DATA_W-1:0]   pers_low,             // filtered pair, lower limit
	input  wire logic [DATA_W-1:0]   pers_high,            // filtered pair, upper limit
	input  wire logic [PERS_W-1:0]   pers_count,           // consecutive conversions needed
	input  wire logic                pers_int_en,          // filtered source reaches the pin
	input  wire logic [DATA_W-1:0]   imm_low,              // immediate pair, lower limit
	input  wire logic [DATA_W-1:0]   imm_high,             // immediate pair, upper limit
	input  wire logic                imm_int_en,           // immediate source reaches the pin
	input  wire logic                scl_in,               // serial clock pin
	input  wire logic                sda_in,               // serial data pin level
	output      logic                sda_out,              // serial data drive value
	output      logic                sda_oe_n,             // serial data enable, low drives
	output      logic                int_out,              // interrupt drive value
	output      logic                int_oe_n,             // interrupt enable, low pulls pin
	output      logic [DATA_W-1:0]   ch0_data,             // channel 0 result
	output      logic [DATA_W-1:0]   ch1_data,             // channel 1 result
	output      logic                conv_done,            // one-cycle pulse per new result
	output      logic                pers_flag,            // filtered source pending
	output      logic                imm_flag              // immediate source pending
);
	import light_readout_pkg::*;

	localparam int          STEP_W   = $clog2(STEP_LEN + 1);
	localparam logic [STEP_W-1:0] STEP_END = STEP_W'(STEP_LEN - 1);

	conv_state_e         state_reg;
	logic [STEP_W-1:0]   step_cnt_reg;
	logic [ITIME_W-1:0]  step_idx_reg;
	logic [DATA_W-1:0]   acc0_reg, acc1_reg;
	logic [PERS_W-1:0]   out_run_reg;
	logic [1:0]          clear_req;
	logic                int_low_reg;

	// codes beyond 101b have no longer period; hold them at six steps
	function automatic logic [ITIME_W-1:0] last_step(input logic [ITIME_W-1:0] sel);
		last_step = (sel > ITIME_MAX) ? ITIME_MAX : sel;
	endfunction : last_step

	// saturating increment of one accumulator
	function automatic logic [DATA_W-1:0] sat_inc(input logic [DATA_W-1:0] v, input logic t);
		sat_inc = (t && v != FULL_SCALE) ? v + 16'h0001 : v;
	endfunction : sat_inc

	function automatic logic outside(input logic [DATA_W-1:0] v, input logic [DATA_W-1:0] lo,
	                                 input logic [DATA_W-1:0] hi);
		outside = (v < lo) || (v > hi);
	endfunction : outside

	wire period_end = (step_cnt_reg == STEP_END) &&
	                  (step_idx_reg == last_step(integration_time_sel));

	// sequencer: integrate, hand results over, evaluate, and loop without a command
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			state_reg <= CONV_INTEG;
		end else begin
			case (state_reg)
				CONV_INTEG: state_reg <= period_end ? CONV_XFER : CONV_INTEG;
				CONV_XFER:  state_reg <= CONV_EVAL;
				CONV_EVAL:  state_reg <= CONV_INTEG;
				default:    state_reg <= CONV_INTEG;
			endcase
		end
	end

	// step timer; time code is read live so a change lands on the running period
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			step_cnt_reg <= '0;
			step_idx_reg <= ITIME_RST;
		end else if (state_reg != CONV_INTEG || period_end) begin
			step_cnt_reg <= '0;
			step_idx_reg <= ITIME_RST;
		end else if (step_cnt_reg == STEP_END) begin
			step_cnt_reg <= '0;
			step_idx_reg <= step_idx_reg + 3'h1;
		end else begin
			step_cnt_reg <= step_cnt_reg + STEP_W'(1);
		end
	end

	// both accumulators share one period; the transfer cycle already counts for the next
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			acc0_reg <= DATA_RST;
			acc1_reg <= DATA_RST;
		end else if (state_reg == CONV_XFER) begin
			acc0_reg <= {15'h0000, adc0_tick};
			acc1_reg <= {15'h0000, adc1_tick};
		end else begin
			acc0_reg <= sat_inc(acc0_reg, adc0_tick);
			acc1_reg <= sat_inc(acc1_reg, adc1_tick);
		end
	end

	// result registers load together in one edge; reads snapshot both at once
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			ch0_data  <= DATA_RST;
			ch1_data  <= DATA_RST;
			conv_done <= 1'b0;
		end else begin
			conv_done <= (state_reg == CONV_XFER);
			if (state_reg == CONV_XFER) begin
				ch0_data <= acc0_reg;
				ch1_data <= acc1_reg;
			end
		end
	end

	// run length of out-of-range conversions, saturating so it never wraps to zero
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			out_run_reg <= PERS_RST;
		end else if (state_reg == CONV_EVAL) begin
			if (!outside(ch0_data, pers_low, pers_high)) begin
				out_run_reg <= PERS_RST;
			end else if (out_run_reg != {PERS_W{1'b1}}) begin
				out_run_reg <= out_run_reg + 4'h1;
			end
		end
	end

	wire pers_hit = (state_reg == CONV_EVAL) && outside(ch0_data, pers_low, pers_high) &&
	                ({1'b0, out_run_reg} + 5'h01 >= {1'b0, pers_count});
	wire imm_hit  = (state_reg == CONV_EVAL) && outside(ch0_data, imm_low, imm_high);

	// sticky flags: a new event in the clearing cycle wins over the clear
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			pers_flag <= 1'b0;
			imm_flag  <= 1'b0;
		end else begin
			if (pers_hit) begin
				pers_flag <= 1'b1;
			end else if (clear_req[CLR_PERS_BIT]) begin
				pers_flag <= 1'b0;
			end
			if (imm_hit) begin
				imm_flag <= 1'b1;
			end else if (clear_req[CLR_IMM_BIT]) begin
				imm_flag <= 1'b0;
			end
		end
	end

	// pin follows the enabled flags one cycle later, as a clean registered level
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			int_low_reg <= 1'b0;
		end else begin
			int_low_reg <= (pers_flag & pers_int_en) | (imm_flag & imm_int_en);
		end
	end

	assign int_out  = 1'b0;
	assign int_oe_n = ~int_low_reg;

	// host port: reads return a frozen pair, writes clear flags
	serial_target #(
		.ADDR      (TARGET_ADDR)
	) u_serial (
		.clock     (clock),
		.resetn    (resetn),
		.scl_in    (scl_in),
		.sda_in    (sda_in),
		.sda_out   (sda_out),
		.sda_oe_n  (sda_oe_n),
		.snap_data ({ch1_data, ch0_data}),
		.clear_req (clear_req)
	);

endmodule : light_readout

// [logic/light_readout_pkg.sv]
// shared constants for the dual channel light readout
package light_readout_pkg;

	// clock and integration timing
	localparam int unsigned CLK_KHZ       = 25000;          // system clock, kHz
	localparam int unsigned STEP_MS       = 100;            // one integration step, ms
	localparam int unsigned STEP_CYCLES   = STEP_MS * CLK_KHZ;

	// integration time select code
	localparam int          ITIME_W       = 3;
	localparam logic [2:0]  ITIME_MAX     = 3'h5;           // code 101b, six steps
	localparam logic [2:0]  ITIME_RST     = 3'h0;

	// result format
	localparam int          DATA_W        = 16;
	localparam logic [15:0] FULL_SCALE    = 16'hffff;
	localparam logic [15:0] DATA_RST      = 16'h0000;

	// persistence filter
	localparam int          PERS_W        = 4;
	localparam logic [3:0]  PERS_RST      = 4'h0;

	// serial target port
	localparam logic [6:0]  TARGET_ADDR   = 7'h29;
	localparam logic [3:0]  BITS_PER_BYTE = 4'h8;
	localparam int          SNAP_W        = 32;             // ch1 hi, ch1 lo, ch0 hi, ch0 lo
	localparam logic [1:0]  BYTE_LAST     = 2'h3;
	localparam int          CLR_PERS_BIT  = 0;              // write data bit: clear persist flag
	localparam int          CLR_IMM_BIT   = 1;              // write data bit: clear immediate flag

	// conversion sequencer
	typedef enum logic [2:0] {
		CONV_INTEG = 3'b001,
		CONV_XFER  = 3'b010,
		CONV_EVAL  = 3'b100
	} conv_state_e;

	// serial target sequencer
	typedef enum logic [6:0] {
		SER_IDLE     = 7'b0000001,
		SER_ADDR     = 7'b0000010,
		SER_ADDR_ACK = 7'b0000100,
		SER_WRITE    = 7'b0001000,
		SER_WR_ACK   = 7'b0010000,
		SER_READ     = 7'b0100000,
		SER_RD_ACK   = 7'b1000000
	} ser_state_e;

endpackage : light_readout_pkg

// [logic/serial_target.sv]
// two-wire serial target: snapshot reads of both channels, flag clears by write
module serial_target
	import light_readout_pkg::*;
#(
	parameter logic [6:0] ADDR = TARGET_ADDR
) (
	input  wire logic                    clock,      // system clock
	input  wire logic                    resetn,     // async reset, active low
	input  wire logic                    scl_in,     // serial clock pin
	input  wire logic                    sda_in,     // serial data pin level
	output      logic                    sda_out,    // serial data drive value
	output      logic                    sda_oe_n,   // low while pulling data low
	input  wire logic [SNAP_W-1:0]       snap_data,  // live result pair
	output      logic [1:0]              clear_req   // one-cycle flag clear pulses
);
	import light_readout_pkg::*;

	logic       scl_s1, scl_s2, scl_s3;
	logic       sda_s1, sda_s2, sda_s3;
	ser_state_e state_reg;
	logic [3:0] bit_cnt_reg;
	logic [7:0] rx_reg;
	logic [7:0] tx_reg;
	logic [1:0] byte_idx_reg;
	logic [SNAP_W-1:0] snap_reg;
	logic       nack_reg;
	logic       drive_low_reg;
	logic [7:0] first_byte;
	logic [7:0] next_byte;

	// pick one byte of the held result pair
	function automatic logic [7:0] pick_byte(input logic [SNAP_W-1:0] s, input logic [1:0] i);
		pick_byte = s[{i, 3'h0} +: 8];
	endfunction : pick_byte

	// bytes to load at the start of a read and after each acknowledged byte
	assign first_byte = pick_byte(snap_reg, 2'h0);
	assign next_byte  = pick_byte(snap_reg, byte_idx_reg);

	// pins come from the bus clock domain: two flops, third only for edges
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			{scl_s1, scl_s2, scl_s3} <= 3'h7;
			{sda_s1, sda_s2, sda_s3} <= 3'h7;
		end else begin
			{scl_s1, scl_s2, scl_s3} <= {scl_in, scl_s1, scl_s2};
			{sda_s1, sda_s2, sda_s3} <= {sda_in, sda_s1, sda_s2};
		end
	end

	wire scl_rise = scl_s2 & ~scl_s3;
	wire scl_fall = ~scl_s2 & scl_s3;
	wire start_c  = scl_s2 & scl_s3 & sda_s3 & ~sda_s2;
	wire stop_c   = scl_s2 & scl_s3 & ~sda_s3 & sda_s2;
	wire full     = (bit_cnt_reg == BITS_PER_BYTE);

	// bit counter and receive shifter run on rising clock edges
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			bit_cnt_reg <= 4'h0;
			rx_reg      <= 8'h00;
			nack_reg    <= 1'b1;
		end else if (start_c || (scl_fall && full)) begin
			bit_cnt_reg <= 4'h0;
		end else if (scl_rise) begin
			if (state_reg == SER_RD_ACK) begin
				nack_reg <= sda_s2;
			end else if (state_reg != SER_ADDR_ACK && state_reg != SER_WR_ACK) begin
				// acknowledge slots must not shift in, or the direction bit is lost
				bit_cnt_reg <= bit_cnt_reg + 4'h1;
				rx_reg      <= {rx_reg[6:0], sda_s2};
			end
		end
	end

	// byte sequencer; bus changes only while the clock is low, so act on falls
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			state_reg     <= SER_IDLE;
			tx_reg        <= 8'h00;
			byte_idx_reg  <= 2'h0;
			snap_reg      <= '0;
			drive_low_reg <= 1'b0;
			clear_req     <= 2'h0;
		end else begin
			clear_req <= 2'h0;
			if (stop_c) begin
				state_reg     <= SER_IDLE;
				drive_low_reg <= 1'b0;
			end else if (start_c) begin
				state_reg     <= SER_ADDR;
				drive_low_reg <= 1'b0;
			end else if (scl_fall) begin
				case (state_reg)
					SER_ADDR: begin
						if (full && rx_reg[7:1] == ADDR) begin
							state_reg     <= SER_ADDR_ACK;
							drive_low_reg <= 1'b1;
							snap_reg      <= snap_data;   // freeze the pair for this read
							byte_idx_reg  <= 2'h0;
						end else if (full) begin
							state_reg <= SER_IDLE;
						end
					end
					SER_ADDR_ACK: begin
						if (rx_reg[0]) begin
							state_reg     <= SER_READ;
							tx_reg        <= {first_byte[6:0], 1'b0};
							drive_low_reg <= ~first_byte[7];
							byte_idx_reg  <= 2'h1;
						end else begin
							state_reg     <= SER_WRITE;
							drive_low_reg <= 1'b0;
						end
					end
					SER_WRITE: begin
						if (full) begin
							state_reg     <= SER_WR_ACK;
							drive_low_reg <= 1'b1;
							clear_req     <= {rx_reg[CLR_IMM_BIT], rx_reg[CLR_PERS_BIT]};
						end
					end
					SER_WR_ACK: begin
						state_reg     <= SER_WRITE;
						drive_low_reg <= 1'b0;
					end
					SER_READ: begin
						if (full) begin
							state_reg     <= SER_RD_ACK;
							drive_low_reg <= 1'b0;
						end else begin
							drive_low_reg <= ~tx_reg[7];
							tx_reg        <= {tx_reg[6:0], 1'b0};
						end
					end
					SER_RD_ACK: begin
						if (!nack_reg) begin
							state_reg     <= SER_READ;
							tx_reg        <= {next_byte[6:0], 1'b0};
							drive_low_reg <= ~next_byte[7];
							byte_idx_reg  <= (byte_idx_reg == BYTE_LAST) ? 2'h0
							                 : byte_idx_reg + 2'h1;
						end else begin
							state_reg <= SER_IDLE;
						end
					end
					SER_IDLE: state_reg <= SER_IDLE;
					default:  state_reg <= SER_IDLE;
				endcase
			end
		end
	end

	// open drain: value is always low, only the enable moves
	assign sda_out  = 1'b0;
	assign sda_oe_n = ~drive_low_reg;

endmodule : serial_target

// [test/light_readout_checker.sv]
// assertion checker on the light readout top ports
module light_readout_checker
	import light_readout_pkg::*;
#(
	parameter int unsigned STEP_LEN = 50	// cycles per integration step
) (
	input wire logic	clock,	// system clock
	input wire logic	resetn,	// async reset, active low
	input wire logic [light_readout_pkg::ITIME_W-1:0]	integration_time_sel,	// time code
	input wire logic [light_readout_pkg::DATA_W-1:0]	pers_low,	// filtered lower limit
	input wire logic [light_readout_pkg::DATA_W-1:0]	pers_high,	// filtered upper limit
	input wire logic [light_readout_pkg::PERS_W-1:0]	pers_count,	// run length needed
	input wire logic [light_readout_pkg::DATA_W-1:0]	imm_low,	// immediate lower limit
	input wire logic [light_readout_pkg::DATA_W-1:0]	imm_high,	// immediate upper limit
	input wire logic	pers_int_en,	// filtered gate
	input wire logic	imm_int_en,	// immediate gate
	input wire logic	sda_out,	// data drive value
	input wire logic	int_out,	// interrupt drive value
	input wire logic	int_oe_n,	// interrupt pulled low
	input wire logic [light_readout_pkg::DATA_W-1:0]	ch0_data,	// channel 0 result
	input wire logic [light_readout_pkg::DATA_W-1:0]	ch1_data,	// channel 1 result
	input wire logic	conv_done,	// new result pulse
	input wire logic	pers_flag,	// filtered pending
	input wire logic	imm_flag	// immediate pending
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!resetn);

	logic [31:0]	gap_reg;	// cycles since the last new result
	logic	seen_reg;	// the first gap after reset is not a full period
	logic [31:0]	steps;
	logic [31:0]	per_len;
	logic	irq_src;

	// codes above six steps clamp to six
	assign steps = (integration_time_sel > 3'h5) ? 32'h6 : 32'(integration_time_sel) + 32'h1;
	assign per_len = steps * STEP_LEN + 32'h2;
	assign irq_src = (pers_flag && pers_int_en) || (imm_flag && imm_int_en);

	// gap counter restarts on every new result
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			gap_reg <= 32'h0;
			seen_reg <= 1'b0;
		end else begin
			gap_reg <= conv_done ? 32'h1 : gap_reg + 32'h1;
			seen_reg <= seen_reg | conv_done;
		end
	end

	sequence s_quiet;
		!conv_done [*8];
	endsequence
	sequence s_imm_out;
		conv_done && (ch0_data > imm_high || ch0_data < imm_low);
	endsequence
	sequence s_pers_out;
		conv_done && pers_count <= 4'h1 && (ch0_data > pers_high || ch0_data < pers_low);
	endsequence

	property p_done_gap; conv_done |=> s_quiet; endproperty
	property p_period; conv_done && seen_reg |-> gap_reg == per_len; endproperty
	property p_data_hold; !conv_done |-> $stable(ch0_data) && $stable(ch1_data); endproperty
	property p_imm_hit; s_imm_out |=> imm_flag; endproperty
	property p_imm_when; $rose(imm_flag) |-> $past(conv_done); endproperty
	property p_pers_first; s_pers_out |=> pers_flag; endproperty
	property p_pers_when; $rose(pers_flag) |-> $past(conv_done); endproperty
	property p_int_level; 1'b1 |=> int_oe_n == !$past(irq_src); endproperty
	property p_drain; int_out == 1'b0 && sda_out == 1'b0; endproperty

	a_done_gap: assert property (p_done_gap) else $error("result pulse repeats too soon");
	a_period: assert property (p_period) else $error("conversion period wrong");
	a_data_hold: assert property (p_data_hold) else $error("data moved without a result");
	a_imm_hit: assert property (p_imm_hit) else $error("immediate flag missed");
	a_imm_when: assert property (p_imm_when) else $error("immediate flag set off cycle");
	a_pers_first: assert property (p_pers_first) else $error("filtered flag missed");
	a_pers_when: assert property (p_pers_when) else $error("filtered flag set off cycle");
	a_int_level: assert property (p_int_level) else $error("interrupt pin wrong");
	a_drain: assert property (p_drain) else $error("open drain drives high");
endmodule : light_readout_checker

// [test/serial_controller.sv]
// serial bus controller model facing the light readout target port
module serial_controller (
	input  wire logic	clock,	// paces the bus
	input  wire logic	sda_line,	// resolved data line
	output      logic	scl_drv,	// bus clock, stands high between frames
	output      logic	sda_oe_n	// low while pulling data low
);
	timeunit 1ns;
	timeprecision 1ns;

	// bus idles released
	initial begin
		scl_drv = 1'b1;
		sda_oe_n = 1'b1;
	end

	// one bit: data moves mid low phase, 4 cycles low, 4 high, 320 ns a bit
	task automatic bit_slot(input logic b, output logic r);
		sda_oe_n <= b;
		repeat (2) @(posedge clock);
		scl_drv <= 1'b1;
		repeat (4) @(posedge clock);
		r = sda_line;
		scl_drv <= 1'b0;
		repeat (2) @(posedge clock);
	endtask : bit_slot

	// data falls while the clock is high
	task automatic start_cond();
		sda_oe_n <= 1'b0;
		repeat (4) @(posedge clock);
		scl_drv <= 1'b0;
		repeat (2) @(posedge clock);
	endtask : start_cond

	// data rises while the clock is high, then the bus rests
	task automatic stop_cond();
		sda_oe_n <= 1'b0;
		repeat (2) @(posedge clock);
		scl_drv <= 1'b1;
		repeat (2) @(posedge clock);
		sda_oe_n <= 1'b1;
		repeat (4) @(posedge clock);
	endtask : stop_cond

	// msb first, the target pulls low in the ninth slot to accept
	task automatic wr_byte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--)
			bit_slot(d[i], r);
		bit_slot(1'b1, r);
		ack = !r;
	endtask : wr_byte

	// msb first, nack on the last byte ends the read
	task automatic rd_byte(output logic [7:0] d, input logic last);
		logic r;
		for (int i = 7; i >= 0; i--)
			bit_slot(1'b1, d[i]);
		bit_slot(last, r);
	endtask : rd_byte
endmodule : serial_controller

// [test/light_readout_test.sv]
// self-checking bench for the light readout with a serial controller model
module light_readout_test;
	timeunit 1ns;
	timeprecision 1ns;
	import light_readout_pkg::*;

	localparam int STEP = 50;	// short step keeps the run brief
	localparam int LIMIT = 30000;	// cycles before the run counts as hung

	logic	clock = 1'b0;
	logic	resetn = 1'b0;
	logic [2:0]	sel = 3'h0;
	logic	adc0_tick = 1'b0;
	logic	adc1_tick = 1'b0;
	logic [15:0]	pers_low, pers_high, imm_low, imm_high, ch0_data, ch1_data, acc0, acc1, n0, n1;
	logic [3:0]	pers_count, run;
	logic	pers_int_en, imm_int_en, scl, host_oe_n, sda_line, ack, ack2, hit, iexp;
	logic	sda_out, sda_oe_n, int_out, int_oe_n, conv_done, pers_flag, imm_flag;
	logic	exp_imm, exp_pers;
	logic [47:0]	e;
	logic [47:0]	exp_q [$];
	logic [31:0]	rnd = 32'h45ce;
	logic [31:0]	snap, held;
	logic [7:0]	b [4];
	int	miscompares = 0, n_tests = 0, cycles = 0, since = 0, last_c = 0, p;

	always #20 clock = ~clock;

	function automatic logic [31:0] xorshift(input logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		return x;
	endfunction : xorshift

	function automatic int period(input logic [2:0] s);
		return ((s > 3'h5) ? 6 : int'(s) + 1) * STEP;
	endfunction : period

	task automatic check(input logic [31:0] got, input logic [31:0] want);
		n_tests++;
		if (got !== want) begin
			miscompares++;
			$display("unexpected at %0t: got %h exp %h", $time, got, want);
		end
	endtask : check

	task automatic final_report();
		$display("comparisons %0d miscompares %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : final_report

	task automatic wait_conv(input int n);
		repeat (n) @(posedge clock iff since == 1);
	endtask : wait_conv

	// the data line is pulled up, either party may pull it low
	assign sda_line = (sda_oe_n == 1'b0 || host_oe_n == 1'b0) ? 1'b0 : 1'b1;

	light_readout #(.STEP_LEN(STEP)) light_readout_i (
		.clock, .resetn, .integration_time_sel(sel), .adc0_tick, .adc1_tick,
		.pers_low, .pers_high, .pers_count, .pers_int_en, .imm_low, .imm_high, .imm_int_en,
		.scl_in(scl), .sda_in(sda_line), .sda_out, .sda_oe_n, .int_out, .int_oe_n,
		.ch0_data, .ch1_data, .conv_done, .pers_flag, .imm_flag
	);

	serial_controller serial_controller_i (
		.clock, .sda_line, .scl_drv(scl), .sda_oe_n(host_oe_n)
	);

	// random ticks, quiet around each transfer so every count lands in a known period
	always @(posedge clock) begin
		if (!resetn) begin
			since <= 0;
			acc0 = 16'h0;
			acc1 = 16'h0;
		end else begin
			p = period(sel);
			n0 = acc0 + 16'(adc0_tick);
			n1 = acc1 + 16'(adc1_tick);
			acc0 = (since == p - 6) ? 16'h0 : n0;
			acc1 = (since == p - 6) ? 16'h0 : n1;
			if (since == p - 6)
				exp_q.push_back({16'(p + 2), n1, n0});
			since <= conv_done ? 0 : since + 1;
			rnd = xorshift(rnd);
			adc0_tick <= (since < 4 || since >= p - 8) ? 1'b0 : rnd[0];
			adc1_tick <= (since < 4 || since >= p - 8) ? 1'b0 : rnd[1];
		end
	end

	// each new result takes the oldest note; flags seen here come from earlier results
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == LIMIT) begin
			miscompares++;
			final_report();
		end
		if (!resetn) begin
			exp_imm = 1'b0;
			exp_pers = 1'b0;
			run = 4'h0;
		end else if (conv_done) begin
			e = (exp_q.size() > 0) ? exp_q.pop_front() : 48'hx;
			iexp = !((exp_imm && imm_int_en) || (exp_pers && pers_int_en));
			check({ch1_data, ch0_data}, e[31:0]);
			if (last_c != 0)
				check(32'(cycles - last_c), {16'h0, e[47:32]});
			check(32'({pers_flag, imm_flag, int_oe_n}), 32'({exp_pers, exp_imm, iexp}));
			hit = e[15:0] > pers_high || e[15:0] < pers_low;
			run = hit ? ((run == 4'hf) ? run : run + 4'h1) : 4'h0;
			exp_pers = exp_pers | (hit && run >= pers_count);
			exp_imm = exp_imm | e[15:0] > imm_high | e[15:0] < imm_low;
			snap = e[31:0];
			last_c = cycles;
		end
	end

	initial begin
		{pers_low, imm_low} = 32'h0;
		{pers_high, imm_high} = 32'hffff_ffff;
		pers_count = 4'h1;
		{pers_int_en, imm_int_en} = 2'h0;
		repeat (6) @(posedge clock);
		resetn <= 1'b1;
		// every time code, the top two acting as the longest
		for (int s = 0; s < 8; s++) begin
			wait_conv(2);
			sel <= 3'(s);
		end
		// a foreign address is left unanswered
		wait_conv(2);
		serial_controller_i.start_cond();
		serial_controller_i.wr_byte(8'h54, ack);
		serial_controller_i.stop_cond();
		check(32'(ack), 32'h0);
		// a read that spans a transfer still returns one pair
		wait_conv(1);
		held = snap;
		serial_controller_i.start_cond();
		serial_controller_i.wr_byte({TARGET_ADDR, 1'b1}, ack);
		for (int i = 0; i < 4; i++)
			serial_controller_i.rd_byte(b[i], i == 3);
		serial_controller_i.stop_cond();
		check({b[3], b[2], b[1], b[0]}, held);
		check(32'(ack), 32'h1);
		// each gate mix: raise both sources, hold, then clear by a write
		for (int k = 0; k < 4; k++) begin
			wait_conv(1);
			{pers_int_en, imm_int_en} <= 2'(k);
			imm_high <= 16'h0;
			pers_low <= 16'h0100;
			pers_count <= {2'h0, rnd[1:0]};
			wait_conv(3);
			imm_high <= 16'hffff;
			pers_low <= 16'h0;
			serial_controller_i.start_cond();
			serial_controller_i.wr_byte({TARGET_ADDR, 1'b0}, ack);
			serial_controller_i.wr_byte(8'h03, ack2);
			serial_controller_i.stop_cond();
			exp_imm = 1'b0;
			exp_pers = 1'b0;
			check(32'({ack, ack2}), 32'h3);
		end
		wait_conv(2);
		final_report();
	end
endmodule : light_readout_test

bind light_readout light_readout_checker #(.STEP_LEN(STEP_LEN)) light_readout_checker_i (
	.clock, .resetn, .integration_time_sel, .pers_low, .pers_high, .pers_count, .imm_low,
	.imm_high, .pers_int_en, .imm_int_en, .sda_out, .int_out, .int_oe_n, .ch0_data,
	.ch1_data, .conv_done, .pers_flag, .imm_flag
);
